// ===== cifp_ctrl.sv
// compare flag register file, priority resolver and vector handshake
// assumes timer match levels and rollover pulses synchronous to pclk
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module cifp_ctrl (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // timer events
    input  wire logic [7:0]  cm_match,
    input  wire logic [7:0]  cc_match,
    input  wire logic [7:0]  cc_capture,
    input  wire logic        ct_rollover,
    input  wire logic        ct_at_reload,
    input  wire logic        ct1_rollover,
    input  wire logic        ct1_at_reload,
    input  wire logic        set_match,
    input  wire logic        clear_match,
    // other sources of the core, own positions ignored
    input  wire logic [18:0] other_req,
    // core sequencer
    input  wire logic        sample_strobe,
    input  wire logic        vector_ack,
    input  wire logic        return_done,
    output logic             irq_req,
    output logic      [4:0]  irq_source,
    output logic      [1:0]  irq_level
);

    // ========================================================
    // state
    typedef struct packed {
        logic [7:0]  cm_flags;
        logic [7:0]  cc_flags;
        logic        compare_timer_overflow_flag;
        logic        second_timer_overflow_flag;
        logic        set_match_request_flag;
        logic        clear_match_request_flag;
        logic [7:0]  tctrl_store;
        logic [7:0]  t1ctrl_store;
        logic [5:0]  prio_lo;
        logic [5:0]  prio_hi;
        logic [7:0]  ch_sel;
        logic [7:0]  ch_en;
        logic [7:0]  cc_en;
        logic [7:0]  cc_cap;
        logic [18:0] irq_en;
        logic [1:0]  match_en;
        logic [18:0] sampled;
        logic [3:0]  active;
        logic        irq_req;
        logic [4:0]  irq_source;
        logic [1:0]  irq_level;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cifp_state_type;

    cifp_state_type st;
    cifp_state_type next_st;

    logic        wr_fire;
    logic [7:0]  idx;
    logic [7:0]  wbyte;
    logic [18:0] req;
    logic        setm_hold;
    logic        clrm_hold;
    logic        best_found;
    logic [4:0]  best_src;
    logic [1:0]  best_lvl;
    logic        act_any;
    logic [1:0]  act_lvl;
    logic [1:0]  lvl;
    logic [31:0] rd;
    logic        hit;

    assign idx     = paddr[9:2];
    assign wbyte   = pwdata[7:0];
    assign wr_fire = psel && penable && st.pready && pwrite;
    assign setm_hold = set_match && st.match_en[0];
    assign clrm_hold = clear_match && st.match_en[1];

    // ========================================================
    // request vector and resolver
    always_comb begin
        req = other_req;
        req[cifp_pkg::SRC_CM]   = |st.cm_flags;
        req[cifp_pkg::SRC_CC]   = |st.cc_flags;
        req[cifp_pkg::SRC_OVF]  = st.compare_timer_overflow_flag;
        req[cifp_pkg::SRC_OVF1] = st.second_timer_overflow_flag;
        req[cifp_pkg::SRC_SETM] = st.set_match_request_flag;
        req[cifp_pkg::SRC_CLRM] = st.clear_match_request_flag;
    end

    always_comb begin
        best_found = 1'b0;
        best_src   = 5'h00;
        best_lvl   = 2'h0;
        lvl        = 2'h0;
        // highest level, lowest index wins a tie
        for (int i = cifp_pkg::NUM_SRC - 1; i >= 0; i--) begin
            lvl = {st.prio_hi[cifp_pkg::cifp_group(5'(i))],
                   st.prio_lo[cifp_pkg::cifp_group(5'(i))]};
            if (st.sampled[i] && st.irq_en[i]
                    && (!best_found || lvl >= best_lvl)) begin
                best_found = 1'b1;
                best_src   = 5'(i);
                best_lvl   = lvl;
            end
        end
        act_any = |st.active;
        act_lvl = st.active[3] ? 2'h3 : st.active[2] ? 2'h2 :
                  st.active[1] ? 2'h1 : 2'h0;
    end

    // ========================================================
    // apb read mux
    always_comb begin
        rd  = 32'h0000_0000;
        hit = 1'b1;
        unique case (idx)
            cifp_pkg::IDX_T1CTRL: begin
                rd[7:0] = st.t1ctrl_store;
                rd[cifp_pkg::T1CTRL_OVF] = st.second_timer_overflow_flag;
            end
            cifp_pkg::IDX_TCTRL: begin
                rd[7:0] = st.tctrl_store;
                rd[cifp_pkg::TCTRL_CLRM] = st.clear_match_request_flag;
                rd[cifp_pkg::TCTRL_SETM] = st.set_match_request_flag;
                rd[cifp_pkg::TCTRL_OVF] = st.compare_timer_overflow_flag;
            end
            cifp_pkg::IDX_CCFLAGS:  rd[7:0]  = st.cc_flags;
            cifp_pkg::IDX_CMFLAGS:  rd[7:0]  = st.cm_flags;
            cifp_pkg::IDX_PRIO_LO:  rd[5:0]  = st.prio_lo;
            cifp_pkg::IDX_PRIO_HI:  rd[5:0]  = st.prio_hi;
            cifp_pkg::IDX_CH_SEL:   rd[7:0]  = st.ch_sel;
            cifp_pkg::IDX_CH_EN:    rd[7:0]  = st.ch_en;
            cifp_pkg::IDX_CC_EN:    rd[7:0]  = st.cc_en;
            cifp_pkg::IDX_CC_CAP:   rd[7:0]  = st.cc_cap;
            cifp_pkg::IDX_IRQ_EN:   rd[18:0] = st.irq_en;
            cifp_pkg::IDX_MATCH_EN: rd[1:0]  = st.match_en;
            cifp_pkg::IDX_STATUS:   rd[3:0]  = st.active;
            default:                hit      = 1'b0;
        endcase
        if (paddr[11:10] != 2'h0) begin
            hit = 1'b0;
            rd  = 32'h0000_0000;
        end
    end

    // ========================================================
    // next state
    always_comb begin
        next_st = st;

        // zero wait state: answer in the first access cycle
        next_st.pready  = psel && !penable;
        next_st.pslverr = psel && !penable && !hit;
        if (psel && !penable) begin
            next_st.prdata = pwrite ? 32'h0000_0000 : rd;
        end

        // software writes; flags take the written value, cm flags only on enabled channels on timer 2
        if (wr_fire && hit) begin
            unique case (idx)
                cifp_pkg::IDX_T1CTRL: begin
                    next_st.t1ctrl_store = wbyte & cifp_pkg::T1CTRL_STORE;
                    next_st.second_timer_overflow_flag =
                        wbyte[cifp_pkg::T1CTRL_OVF];
                end
                cifp_pkg::IDX_TCTRL: begin
                    next_st.tctrl_store = wbyte & cifp_pkg::TCTRL_STORE;
                    next_st.clear_match_request_flag =
                        wbyte[cifp_pkg::TCTRL_CLRM];
                    next_st.set_match_request_flag =
                        wbyte[cifp_pkg::TCTRL_SETM];
                    next_st.compare_timer_overflow_flag =
                        wbyte[cifp_pkg::TCTRL_OVF];
                end
                cifp_pkg::IDX_CCFLAGS: next_st.cc_flags = wbyte;
                cifp_pkg::IDX_CMFLAGS: begin
                    // clear only on channels on timer 2 and enabled
                    next_st.cm_flags = (st.cm_flags & (st.ch_sel | ~st.ch_en))
                                     | (wbyte & ~st.ch_sel & st.ch_en);
                end
                cifp_pkg::IDX_PRIO_LO:  next_st.prio_lo  = wbyte[5:0];
                cifp_pkg::IDX_PRIO_HI:  next_st.prio_hi  = wbyte[5:0];
                cifp_pkg::IDX_CH_SEL:   next_st.ch_sel   = wbyte;
                cifp_pkg::IDX_CH_EN:    next_st.ch_en    = wbyte;
                cifp_pkg::IDX_CC_EN:    next_st.cc_en    = wbyte;
                cifp_pkg::IDX_CC_CAP:   next_st.cc_cap   = wbyte;
                cifp_pkg::IDX_IRQ_EN:   next_st.irq_en   = pwdata[18:0];
                cifp_pkg::IDX_MATCH_EN: next_st.match_en = wbyte[1:0];
                default: ;
            endcase
        end

        if (vector_ack && st.irq_req) begin
            if (st.irq_source == cifp_pkg::SRC_SETM) begin
                next_st.set_match_request_flag = 1'b0;
            end
            if (st.irq_source == cifp_pkg::SRC_CLRM) begin
                next_st.clear_match_request_flag = 1'b0;
            end
        end

        if (!ct_at_reload) next_st.compare_timer_overflow_flag = 1'b0;
        if (!ct1_at_reload) next_st.second_timer_overflow_flag = 1'b0;

        // hardware sets come last so they win over any clear
        // enabled compare match
        next_st.cm_flags = next_st.cm_flags | (cm_match & st.ch_en);
        next_st.cc_flags = next_st.cc_flags
                         | (cc_match & st.cc_en & ~st.cc_cap)
                         | (cc_capture & st.cc_cap);
        if (ct_rollover) next_st.compare_timer_overflow_flag = 1'b1;
        if (ct1_rollover) next_st.second_timer_overflow_flag = 1'b1;
        if (setm_hold) next_st.set_match_request_flag = 1'b1;
        if (clrm_hold) next_st.clear_match_request_flag = 1'b1;

        if (sample_strobe) begin
            next_st.sampled = req;
        end else if (vector_ack && st.irq_req) begin
            // taken request is not polled again before resample
            next_st.sampled[st.irq_source] = 1'b0;
        end

        // in-service levels
        if (vector_ack && st.irq_req) begin
            next_st.active[st.irq_level] = 1'b1;
        end else if (return_done && act_any) begin
            next_st.active[act_lvl] = 1'b0;
        end

        // only a strictly higher level gets through
        next_st.irq_req = best_found && !(vector_ack && st.irq_req)
                        && (!act_any || best_lvl > act_lvl);
        next_st.irq_source = best_src;
        next_st.irq_level  = best_lvl;
    end

    // ========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st             <= '0;
            st.tctrl_store  <= cifp_pkg::TCTRL_RESET;
            st.t1ctrl_store <= cifp_pkg::T1CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata     = st.prdata;
    assign pready     = st.pready;
    assign pslverr    = st.pslverr;
    assign irq_req    = st.irq_req;
    assign irq_source = st.irq_source;
    assign irq_level  = st.irq_level;

    // ========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cm_match_set: assert property (
        cm_match[0] && st.ch_en[0] |=> st.cm_flags[0])
        else $error("enabled compare match did not set its flag");

    a_cm_disabled_quiet: assert property (
        !st.cm_flags[1] && cm_match[1] && !st.ch_en[1] && !wr_fire
        |=> !st.cm_flags[1])
        else $error("disabled compare channel set its flag");

    a_cc_capture_set: assert property (
        cc_capture[7] && st.cc_cap[7] |=> st.cc_flags[7])
        else $error("capture event did not set its flag");

    a_cc_one_request: assert property (
        sample_strobe
        |=> st.sampled[cifp_pkg::SRC_CC] == |$past(st.cc_flags))
        else $error("capture/compare request is not the or of its flags");

    a_cc_kept_on_vector: assert property (
        vector_ack && st.cc_flags[0] && !wr_fire |=> st.cc_flags[0])
        else $error("capture/compare flag cleared by vectoring");

    a_ovf_set: assert property (
        ct_rollover |=> st.compare_timer_overflow_flag)
        else $error("compare timer rollover did not set its flag");

    a_ovf_hw_clear: assert property (
        st.compare_timer_overflow_flag && !ct_at_reload && !ct_rollover
        |=> !st.compare_timer_overflow_flag)
        else $error("overflow flag stayed after timer left reload");

    a_ovf1_set: assert property (
        ct1_rollover |=> st.second_timer_overflow_flag)
        else $error("timer 1 rollover did not set its flag");

    a_ovf1_hw_clear: assert property (
        st.second_timer_overflow_flag && !ct1_at_reload && !ct1_rollover
        |=> !st.second_timer_overflow_flag)
        else $error("timer 1 overflow flag stayed after leaving reload");

    a_setm_set: assert property (
        set_match && st.match_en[0] |=> st.set_match_request_flag)
        else $error("enabled set match did not set its flag");

    a_setm_held: assert property (
        (set_match && st.match_en[0]) [*2] |=> st.set_match_request_flag)
        else $error("set-match flag lost while match persists");

    a_setm_vector_clear: assert property (
        vector_ack && st.irq_req && st.irq_source == cifp_pkg::SRC_SETM
        && !setm_hold |=> !st.set_match_request_flag)
        else $error("set-match flag not cleared on vectoring");

    a_clrm_vector_clear: assert property (
        vector_ack && st.irq_req && st.irq_source == cifp_pkg::SRC_CLRM
        && !clrm_hold && !wr_fire |=> !st.clear_match_request_flag)
        else $error("clear-match flag not cleared on vectoring");

    a_vector_drops: assert property (
        vector_ack && st.irq_req |=> !st.irq_req)
        else $error("request still raised after the core vectored");

    a_top_level_locks: assert property (
        st.active[3] && !return_done |=> !st.irq_req)
        else $error("request raised during top level routine");

    a_preempt_higher: assert property (
        $rose(st.irq_req) && $past(act_any) && !$past(vector_ack)
        |-> st.irq_level > $past(act_lvl))
        else $error("request at equal or lower level than running one");

    a_sample_hold: assert property (
        !sample_strobe && !vector_ack |=> $stable(st.sampled))
        else $error("sampled requests changed outside the strobe");

    a_apb_answer: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

    c_setm_vector: cover property (
        vector_ack && st.irq_req && st.irq_source == cifp_pkg::SRC_SETM);
    c_preemption: cover property (vector_ack && st.irq_req && act_any);
    c_capture_flag: cover property ($rose(st.cc_flags[7]));
    c_timer1_overflow: cover property (
        $rose(st.second_timer_overflow_flag));

endmodule : cifp_ctrl

// ===== cifp_pkg.sv
// constants for the compare interrupt flag and priority block
// assumes an 8-bit core whose registers are reached through an APB word port
//
// Summary of operation
// - compare match sets its request flag only when that channel is enabled
// - capture/compare flag set by timer 1 match or by capture when selected
// - the eight capture/compare flags are OR-ed into one request
// - compare timer overflow flag set on rollover, requests when enabled
// - compare timer overflow flag cleared once timer leaves reload value
// - timer 1 overflow flag set on rollover, requests when enabled
// - timer 1 overflow flag cleared once timer 1 leaves reload value
// - set-match and clear-match flags set by enabled compare matches
// - while a set or clear match persists its flag ignores every clear
// - set-match and clear-match flags cleared when the core vectors there
// - nineteen sources, each belonging to a fixed group
// - sources form six fixed groups of two to four members
// - each group takes one of four levels from two priority bits
// - only a strictly higher level preempts a running routine
// - a routine at the top level is never preempted
// - among simultaneous requests the highest level is served first
// - equal-level simultaneous requests resolved by fixed polling order
// - polling runs group 1 to 6, then left to right within a group
// - flags sampled on the sample strobe, polled in the next machine cycle
package cifp_pkg;

    // ========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_T1CTRL   = 8'hBC;
    localparam logic [7:0] IDX_CCFLAGS  = 8'hBF;
    localparam logic [7:0] IDX_CMFLAGS  = 8'hD1;
    localparam logic [7:0] IDX_TCTRL    = 8'hE1;
    localparam logic [7:0] IDX_PRIO_LO  = 8'hA9;
    localparam logic [7:0] IDX_PRIO_HI  = 8'hB9;
    localparam logic [7:0] IDX_CH_SEL   = 8'hE2;
    localparam logic [7:0] IDX_CH_EN    = 8'hE3;
    localparam logic [7:0] IDX_CC_EN    = 8'hE4;
    localparam logic [7:0] IDX_CC_CAP   = 8'hE5;
    localparam logic [7:0] IDX_IRQ_EN   = 8'hE6;
    localparam logic [7:0] IDX_MATCH_EN = 8'hE7;
    localparam logic [7:0] IDX_STATUS   = 8'hE8;

    // ========================================================
    // field positions and reset values
    localparam int TCTRL_CLRM  = 7;
    localparam int TCTRL_SETM  = 5;
    localparam int TCTRL_OVF   = 3;
    localparam int T1CTRL_OVF  = 3;
    localparam logic [7:0] TCTRL_RESET  = 8'h40;
    localparam logic [7:0] T1CTRL_RESET = 8'h40;
    localparam logic [7:0] TCTRL_STORE  = 8'h57;
    localparam logic [7:0] T1CTRL_STORE = 8'hF7;

    // ========================================================
    // sources, numbered in polling order
    localparam int NUM_SRC  = 19;
    localparam int NUM_GRP  = 6;
    localparam logic [4:0] SRC_CM   = 5'h06;
    localparam logic [4:0] SRC_CC   = 5'h08;
    localparam logic [4:0] SRC_OVF  = 5'h0A;
    localparam logic [4:0] SRC_OVF1 = 5'h0C;
    localparam logic [4:0] SRC_SETM = 5'h0E;
    localparam logic [4:0] SRC_CLRM = 5'h11;

    // fixed source groups, 0 is the first polled
    function automatic logic [2:0] cifp_group(input logic [4:0] src);
        if (src < 5'h03) return 3'h0;
        else if (src < 5'h05) return 3'h1;
        else if (src < 5'h09) return 3'h2;
        else if (src < 5'h0D) return 3'h3;
        else if (src < 5'h10) return 3'h4;
        else return 3'h5;
    endfunction : cifp_group

endpackage : cifp_pkg

// ===== cifp_core_model.sv
// core sequencer model: sampling strobe, vector take and return
// assumes the block's request outputs are registered on pclk
`timescale 1ns/1ps

module cifp_core_model #(
    parameter int STROBE_DIV = 6
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // bench control
    input  wire logic       grab,
    input  wire logic       finish,
    input  wire logic [3:0] ack_wait,
    // block side
    input  wire logic       irq_req,
    output logic            sample_strobe,
    output logic            vector_ack,
    output logic            return_done
);
    int         div;
    logic [3:0] waited;

    // ========================================================
    // one sampling point per machine cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div           <= 0;
            sample_strobe <= 1'h0;
        end else begin
            div           <= (div == STROBE_DIV - 1) ? 0 : div + 1;
            sample_strobe <= (div == STROBE_DIV - 1);
        end
    end

    // ========================================================
    // a slow core lets ack_wait request cycles pass before taking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            waited      <= 4'h0;
            vector_ack  <= 1'h0;
            return_done <= 1'h0;
        end else begin
            return_done <= finish;
            vector_ack  <= 1'h0;
            if (grab && irq_req && !vector_ack) begin
                if (waited >= ack_wait) begin
                    vector_ack <= 1'h1;
                    waited     <= 4'h0;
                end else begin
                    waited <= waited + 4'h1;
                end
            end
        end
    end

endmodule : cifp_core_model

// ===== cifp_ctrl_tb.sv
// self-checking bench for the compare flag and priority block
// assumes cifp_pkg and the core model are compiled before it
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("wrong value %s exp %h got %h", nm, exp, got); \
        end \
    end

module cifp_ctrl_tb;
    localparam int STROBE_DIV = 6;
    localparam int LIMIT      = 20000;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0]  cm_match, cc_match, cc_capture;
    logic        ct_rollover, ct_at_reload, ct1_rollover, ct1_at_reload;
    logic        set_match, clear_match, rerr, grab, finish;
    logic        sample_strobe, vector_ack, return_done, irq_req;
    logic [18:0] other_req;
    logic [4:0]  irq_source;
    logic [1:0]  irq_level;
    logic [3:0]  ack_wait;
    int          checks, failures;
    int          cycles = 0;

    cifp_ctrl u_cifp_ctrl (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .cm_match, .cc_match, .cc_capture,
        .ct_rollover, .ct_at_reload, .ct1_rollover, .ct1_at_reload,
        .set_match, .clear_match, .other_req, .sample_strobe,
        .vector_ack, .return_done, .irq_req, .irq_source, .irq_level
    );

    cifp_core_model #(.STROBE_DIV(STROBE_DIV)) u_cifp_core_model (
        .pclk, .presetn, .grab, .finish, .ack_wait, .irq_req,
        .sample_strobe, .vector_ack, .return_done
    );

    always #10 pclk = ~pclk;

    // ========================================================
    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            conclude();
        end
    end

    // ========================================================
    // bus and core tasks
    task automatic apb(input logic [7:0] idx, input logic wr,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'h1;
        pwrite  <= wr;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic rd_chk(input string nm, input logic [7:0] idx,
                          input logic [31:0] exp);
        apb(idx, 1'h0, 32'h0);
        `CHK(nm, exp, rdat)
    endtask : rd_chk

    task automatic expect_irq(input logic [4:0] src, input logic [1:0] lv);
        while (irq_req !== 1'h1) @(posedge pclk);
        `CHK("irq_source", src, irq_source)
        `CHK("irq_level", lv, irq_level)
    endtask : expect_irq

    task automatic serve;
        grab <= 1'h1;
        @(posedge pclk);
        while (vector_ack !== 1'h1) @(posedge pclk);
        grab <= 1'h0;
        @(posedge pclk);
    endtask : serve

    task automatic leave;
        finish <= 1'h1;
        @(posedge pclk);
        finish <= 1'h0;
        repeat (2) @(posedge pclk);
    endtask : leave

    task automatic settle;
        while (irq_req !== 1'h0) @(posedge pclk);
    endtask : settle

    task automatic quiet;
        repeat (3 * STROBE_DIV) begin
            @(posedge pclk);
            `CHK("irq_req", 1'h0, irq_req)
        end
    endtask : quiet

    task automatic conclude;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // ========================================================
    // test sequence
    initial begin
        pclk    = 1'h0;
        presetn = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cm_match, cc_match, cc_capture, ack_wait} = '0;
        {ct_rollover, ct_at_reload, ct1_rollover, ct1_at_reload} = '0;
        {set_match, clear_match, other_req, grab, finish} = '0;
        checks   = 0;
        failures = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rd_chk("timer ctrl", cifp_pkg::IDX_TCTRL, 32'h40);
        rd_chk("timer1 ctrl", cifp_pkg::IDX_T1CTRL, 32'h40);
        rd_chk("cm flags", cifp_pkg::IDX_CMFLAGS, 32'h0);
        rd_chk("cc flags", cifp_pkg::IDX_CCFLAGS, 32'h0);
        apb(8'h00, 1'h0, 32'h0);
        `CHK("pslverr", 1'h1, rerr)
        apb(cifp_pkg::IDX_IRQ_EN, 1'h1, 32'h7FFFF);
        $display("done reset");
        apb(cifp_pkg::IDX_CH_EN, 1'h1, 32'h1);
        @(posedge pclk);
        cm_match <= 8'h03;
        @(posedge pclk);
        cm_match <= 8'h00;
        rd_chk("cm flags", cifp_pkg::IDX_CMFLAGS, 32'h1);
        expect_irq(cifp_pkg::SRC_CM, 2'h0);
        apb(cifp_pkg::IDX_CH_EN, 1'h1, 32'h3);
        cm_match <= 8'h02;
        @(posedge pclk);
        cm_match <= 8'h00;
        apb(cifp_pkg::IDX_CH_SEL, 1'h1, 32'h2);
        // software clear, bit 1 still on the other timer
        apb(cifp_pkg::IDX_CMFLAGS, 1'h1, 32'h0);
        rd_chk("cm flags", cifp_pkg::IDX_CMFLAGS, 32'h2);
        apb(cifp_pkg::IDX_CH_SEL, 1'h1, 32'h0);
        cm_match <= 8'h02;
        apb(cifp_pkg::IDX_CMFLAGS, 1'h1, 32'h0);
        cm_match <= 8'h00;
        rd_chk("cm flags", cifp_pkg::IDX_CMFLAGS, 32'h2);
        apb(cifp_pkg::IDX_CMFLAGS, 1'h1, 32'h0);
        rd_chk("cm flags", cifp_pkg::IDX_CMFLAGS, 32'h0);
        $display("done compare match");
        settle;
        apb(cifp_pkg::IDX_CC_EN, 1'h1, 32'h1);
        apb(cifp_pkg::IDX_CC_CAP, 1'h1, 32'h80);
        cc_match   <= 8'h83;
        cc_capture <= 8'h80;
        @(posedge pclk);
        cc_match   <= 8'h00;
        cc_capture <= 8'h00;
        rd_chk("cc flags", cifp_pkg::IDX_CCFLAGS, 32'h81);
        expect_irq(cifp_pkg::SRC_CC, 2'h0);
        ack_wait <= 4'h3;
        serve;
        rd_chk("cc flags", cifp_pkg::IDX_CCFLAGS, 32'h81);
        leave;
        apb(cifp_pkg::IDX_CCFLAGS, 1'h1, 32'h0);
        rd_chk("cc flags", cifp_pkg::IDX_CCFLAGS, 32'h0);
        for (int k = 0; k < 2; k++) begin
            settle;
            ct_at_reload  <= (k == 0);
            ct1_at_reload <= (k == 1);
            ct_rollover   <= (k == 0);
            ct1_rollover  <= (k == 1);
            @(posedge pclk);
            ct_rollover   <= 1'h0;
            ct1_rollover  <= 1'h0;
            rd_chk("ovf", k ? 8'hBC : 8'hE1, 32'h48);
            expect_irq(k ? 5'h0C : 5'h0A, 2'h0);
            ct_at_reload  <= 1'h0;
            ct1_at_reload <= 1'h0;
            rd_chk("ovf", k ? 8'hBC : 8'hE1, 32'h40);
        end
        apb(cifp_pkg::IDX_MATCH_EN, 1'h1, 32'h3);
        for (int k = 0; k < 2; k++) begin
            settle;
            set_match   <= (k == 0);
            clear_match <= (k == 1);
            apb(cifp_pkg::IDX_TCTRL, 1'h1, 32'h40);
            rd_chk("match", cifp_pkg::IDX_TCTRL, k ? 32'hC0 : 32'h60);
            set_match   <= 1'h0;
            clear_match <= 1'h0;
            expect_irq(k ? 5'h11 : 5'h0E, 2'h0);
            serve;
            rd_chk("match", cifp_pkg::IDX_TCTRL, 32'h40);
            leave;
        end
        $display("done flags");
        for (int i = 0; i < 19; i++) begin
            if (i inside {6, 8, 10, 12, 14, 17}) continue;
            settle;
            other_req <= 19'h7FFFF << i;
            expect_irq(5'(i), 2'h0);
            other_req <= 19'h0;
        end
        $display("done polling");
        settle;
        apb(cifp_pkg::IDX_PRIO_LO, 1'h1, 32'h5);
        apb(cifp_pkg::IDX_PRIO_HI, 1'h1, 32'h6);
        other_req <= 19'h00209;
        expect_irq(5'h03, 2'h2);
        serve;
        quiet;
        other_req <= 19'h00229;
        expect_irq(5'h05, 2'h3);
        serve;
        rd_chk("in service", cifp_pkg::IDX_STATUS, 32'hC);
        quiet;
        leave;
        leave;
        rd_chk("in service", cifp_pkg::IDX_STATUS, 32'h0);
        $display("done levels");
        conclude();
    end

endmodule : cifp_ctrl_tb
